/* File: core/i2cbc_consts.vh */
/*
 constants for the two-wire bus controller: register indices, field positions,
 reset values and the base clock count. assumes a 32-bit apb slave where the
 byte address of each register is four times its index.
*/
// Notes on behaviour
// - mode field 00 port (outputs off), 01 synchronous, 10 two-wire, 11 reserved; the code drives the pads only in 10, and 01 acts as 00.
// - writing soft reset field 10 then 01 pulses an internal reset.
// - second control register is write-only; reads return the status register.
// - ack mode adds one clock after the word; transmitter releases data, receiver drives low.
// - without ack mode no acknowledge clock is generated or counted.
// - bit-count field sets the length of the next word.
// - bit-count clears to 000 on start; address word moves as 8 bits.
// - clock-select field sets the highest clock rate driven as master.
// - clock pulled low during our high phase restarts count, drive low.
// - release clock after low count; count high only once line is high.
// - slave compares received address with own address when format bit is 0.
// - role bit clears on stop detection or lost arbitration.
// - addressed slave takes direction from received read/write bit when format bit is 0; with format bit 1 it keeps its direction.
// - master after ack sets direction from sent read/write bit; stop/loss clears.
// - bus free and 1111 written to role/dir/state/pending starts and sends buffer.
// - bus busy and 1101 written starts stop generation.
// - busy flag sets on detected start, clears on detected stop.
// - word end clears pending and holds clock low; buffer access sets it.
// - rising clock compares line with own output; mismatch loses arbitration.
`ifndef I2CBC_CONSTS_VH
`define I2CBC_CONSTS_VH
`define I2CBC_IDX_CR1 10'h240
`define I2CBC_IDX_DBR 10'h241
`define I2CBC_IDX_OAR 10'h242
`define I2CBC_IDX_CR2 10'h243
`define I2CBC_CR2_MST 7
`define I2CBC_CR2_TRX 6
`define I2CBC_CR2_BB 5
`define I2CBC_CR2_PIN 4
`define I2CBC_CR2_MODE_HI 3
`define I2CBC_CR2_MODE_LO 2
`define I2CBC_CR2_SWRST_HI 1
`define I2CBC_CR2_SWRST_LO 0
`define I2CBC_CR1_BC_HI 7
`define I2CBC_CR1_BC_LO 5
`define I2CBC_CR1_ACK 4
`define I2CBC_CR1_SCK_HI 2
`define I2CBC_CR1_SCK_LO 0
`define I2CBC_OAR_SA_HI 7
`define I2CBC_OAR_SA_LO 1
`define I2CBC_OAR_ALS 0
`define I2CBC_MODE_PORT 2'h0
`define I2CBC_MODE_SIO 2'h1
`define I2CBC_MODE_I2C 2'h2
`define I2CBC_SWRST_ARM 2'h2
`define I2CBC_SWRST_FIRE 2'h1
`define I2CBC_CMD_START 4'hF
`define I2CBC_CMD_STOP 4'hD
`define I2CBC_CR1_RST 8'h00
`define I2CBC_OAR_RST 8'h00
`define I2CBC_DBR_RST 8'h00
`define I2CBC_HALF_BASE 12'h010
`endif

/* File: core/i2cbc_ctrl.v */
/*
 two-wire bus master/slave controller with apb register access.
 assumes open-drain pads outside (oe high pulls the line low) and apb on clk_sys_i.
*/
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "i2cbc_consts.vh"
module i2cbc_ctrl #(
    parameter [11:0] HALF_BASE = `I2CBC_HALF_BASE
) (
    input wire clk_sys_i,
    input wire rst_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    output reg [31:0] prdata_o,
    output reg pready_o,
    output reg pslverr_o,
    input wire scl_i,
    output reg scl_o,
    output reg scl_oe_o,
    input wire sda_i,
    output reg sda_o,
    output reg sda_oe_o
);
    localparam [2:0] MS_IDLE = 3'd0;
    localparam [2:0] MS_START = 3'd1;
    localparam [2:0] MS_RUN = 3'd2;
    localparam [2:0] MS_STOP0 = 3'd3;
    localparam [2:0] MS_STOP1 = 3'd4;
    localparam [2:0] MS_STOP2 = 3'd5;
    localparam [1:0] G_LOW = 2'd0;
    localparam [1:0] G_WAIT = 2'd1;
    localparam [1:0] G_HIGH = 2'd2;

    function [3:0] word_len;
        input [2:0] bc;
        input ack;
        begin
            word_len = ((bc == 3'h0) ? 4'h8 : {1'b0, bc}) + {3'h0, ack};
        end
    endfunction

    function [11:0] half_len;
        input [2:0] sck;
        begin
            half_len = HALF_BASE << sck;
        end
    endfunction

    reg scl_s1_q, scl_s2_q, scl_s3_q, sda_s1_q, sda_s2_q, sda_s3_q;
    reg sreset_q;
    reg [7:0] cr1_q, oar_q, shift_q;
    reg mst_q, trx_q, bb_q, pin_q, al_q, aas_q, ad0_q, lrb_q;
    reg [1:0] mode_q, swrst_q, gen_q;
    reg [2:0] ms_q;
    reg [11:0] cnt_q;
    reg [3:0] bit_q;
    reg first_q, addr_rw_q;

    wire srst = rst_i | sreset_q;
    wire [9:0] idx = paddr_i[11:2];
    wire acc = psel_i & penable_i & pready_o;
    wire wr = acc & pwrite_i;
    wire rd = acc & ~pwrite_i;
    wire [7:0] wd = pwdata_i[7:0];
    wire wr_cr1 = wr & (idx == `I2CBC_IDX_CR1);
    wire wr_dbr = wr & (idx == `I2CBC_IDX_DBR);
    wire wr_oar = wr & (idx == `I2CBC_IDX_OAR);
    wire wr_cr2 = wr & (idx == `I2CBC_IDX_CR2);
    wire rd_dbr = rd & (idx == `I2CBC_IDX_DBR);
    wire i2c = (mode_q == `I2CBC_MODE_I2C);
    wire scl_rise = i2c & scl_s2_q & ~scl_s3_q;
    wire scl_fall = i2c & ~scl_s2_q & scl_s3_q;
    wire start_det = i2c & scl_s2_q & scl_s3_q & ~sda_s2_q & sda_s3_q;
    wire stop_det = i2c & scl_s2_q & scl_s3_q & sda_s2_q & ~sda_s3_q;
    wire ack_en = cr1_q[`I2CBC_CR1_ACK];
    wire [2:0] bc = cr1_q[`I2CBC_CR1_BC_HI:`I2CBC_CR1_BC_LO];
    wire [3:0] nbits = word_len(bc, 1'b0);
    wire [3:0] total = word_len(bc, ack_en);
    wire [11:0] half = half_len(cr1_q[`I2CBC_CR1_SCK_HI:`I2CBC_CR1_SCK_LO]);
    wire address_format_bit = oar_q[`I2CBC_OAR_ALS];
    wire gcall = (shift_q == 8'h00);
    wire match = ~address_format_bit & ((shift_q[7:1] == oar_q[`I2CBC_OAR_SA_HI:`I2CBC_OAR_SA_LO]) | gcall);
    wire addressed = first_q & ~mst_q & (match | address_format_bit);
    wire active = mst_q | aas_q | addressed;
    wire acking = mst_q ? ~trx_q : (aas_q ? ~trx_q : (first_q & match));
    wire buf_acc = wr_dbr | rd_dbr;
    wire start_req = wr_cr2 & (wd[7:4] == `I2CBC_CMD_START) & ~bb_q;
    wire stop_req = wr_cr2 & (wd[7:4] == `I2CBC_CMD_STOP) & bb_q;
    wire arb_lost = scl_rise & mst_q & trx_q & (bit_q < nbits) & ~sda_oe_o & ~sda_s2_q;
    wire done = scl_fall & (bit_q == total) & (bit_q != 4'h0);
    wire last_cnt = (cnt_q == half - 12'h001);

    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            scl_s1_q <= 1'b1;
            scl_s2_q <= 1'b1;
            scl_s3_q <= 1'b1;
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
            sda_s3_q <= 1'b1;
        end else begin
            scl_s1_q <= scl_i;
            scl_s2_q <= scl_s1_q;
            scl_s3_q <= scl_s2_q;
            sda_s1_q <= sda_i;
            sda_s2_q <= sda_s1_q;
            sda_s3_q <= sda_s2_q;
        end
    end

    // apb: zero-wait, data prepared in the setup cycle
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
        end else begin
            pready_o <= psel_i & ~penable_i;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
            if (psel_i & ~penable_i) begin
                case (idx)
                    `I2CBC_IDX_CR1: prdata_o <= {24'h000000, cr1_q};
                    `I2CBC_IDX_DBR: prdata_o <= {24'h000000, shift_q};
                    `I2CBC_IDX_OAR: prdata_o <= {24'h000000, oar_q};
                    `I2CBC_IDX_CR2: begin
                        prdata_o <= {24'h000000, mst_q, trx_q, bb_q, pin_q,
                                     al_q, aas_q, ad0_q, lrb_q};
                    end
                    default: pslverr_o <= 1'b1;
                endcase
            end
        end
    end

    // soft reset pulse, one cycle wide; its own register is reset by the pin reset only
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            sreset_q <= 1'b0;
        end else begin
            sreset_q <= wr_cr2 & (swrst_q == `I2CBC_SWRST_ARM) &
                        (wd[1:0] == `I2CBC_SWRST_FIRE);
        end
    end

    always @(posedge clk_sys_i) begin
        if (srst) begin
            cr1_q <= `I2CBC_CR1_RST;
            oar_q <= `I2CBC_OAR_RST;
            shift_q <= `I2CBC_DBR_RST;
            mst_q <= 1'b0;
            trx_q <= 1'b0;
            bb_q <= 1'b0;
            pin_q <= 1'b1;
            al_q <= 1'b0;
            aas_q <= 1'b0;
            ad0_q <= 1'b0;
            lrb_q <= 1'b0;
            mode_q <= `I2CBC_MODE_PORT;
            swrst_q <= 2'h0;
            gen_q <= G_LOW;
            ms_q <= MS_IDLE;
            cnt_q <= 12'h000;
            bit_q <= 4'h0;
            first_q <= 1'b0;
            addr_rw_q <= 1'b0;
            scl_o <= 1'b0;
            sda_o <= 1'b0;
            scl_oe_o <= 1'b0;
            sda_oe_o <= 1'b0;
        end else begin
            // software side
            if (wr_cr1) begin
                cr1_q <= wd;
            end
            if (wr_oar) begin
                oar_q <= wd;
            end
            if (buf_acc) begin
                pin_q <= 1'b1;
                al_q <= 1'b0;
                aas_q <= 1'b0;
            end
            if (wr_dbr) begin
                shift_q <= wd;
                if (trx_q & scl_oe_o) begin
                    sda_oe_o <= ~wd[7];
                end
            end
            if (wr_cr2) begin
                mode_q <= wd[`I2CBC_CR2_MODE_HI:`I2CBC_CR2_MODE_LO];
                swrst_q <= wd[`I2CBC_CR2_SWRST_HI:`I2CBC_CR2_SWRST_LO];
                al_q <= 1'b0;
                if (wd[`I2CBC_CR2_PIN]) begin
                    pin_q <= 1'b1;
                end
                if (start_req) begin
                    mst_q <= 1'b1;
                    trx_q <= 1'b1;
                    addr_rw_q <= shift_q[0];
                    ms_q <= MS_START;
                    cnt_q <= 12'h000;
                end else if (stop_req) begin
                    ms_q <= MS_STOP0;
                    cnt_q <= 12'h000;
                end else if (ms_q == MS_IDLE || ms_q == MS_RUN) begin
                    mst_q <= wd[`I2CBC_CR2_MST];
                    trx_q <= wd[`I2CBC_CR2_TRX];
                end
            end
            // master sequencer and clock generator
            case (ms_q)
                MS_IDLE: begin
                    gen_q <= G_LOW;
                end
                MS_START: begin
                    if (!scl_s2_q) begin
                        cnt_q <= 12'h000;
                    end else if (last_cnt) begin
                        sda_oe_o <= 1'b1;
                        ms_q <= MS_RUN;
                        gen_q <= G_HIGH;
                        cnt_q <= 12'h000;
                    end else begin
                        cnt_q <= cnt_q + 12'h001;
                    end
                end
                MS_RUN: begin
                    case (gen_q)
                        G_LOW: begin
                            scl_oe_o <= 1'b1;
                            if (!pin_q) begin
                                cnt_q <= 12'h000;
                            end else if (last_cnt) begin
                                gen_q <= G_WAIT;
                                scl_oe_o <= 1'b0;
                                cnt_q <= 12'h000;
                            end else begin
                                cnt_q <= cnt_q + 12'h001;
                            end
                        end
                        G_WAIT: begin
                            if (scl_s2_q) begin
                                gen_q <= G_HIGH;
                                cnt_q <= 12'h000;
                            end
                        end
                        G_HIGH: begin
                            if (!scl_s2_q || last_cnt) begin
                                gen_q <= G_LOW;
                                scl_oe_o <= 1'b1;
                                cnt_q <= 12'h000;
                            end else begin
                                cnt_q <= cnt_q + 12'h001;
                            end
                        end
                        default: gen_q <= G_LOW;
                    endcase
                end
                MS_STOP0: begin
                    scl_oe_o <= 1'b1;
                    sda_oe_o <= 1'b1;
                    if (last_cnt) begin
                        ms_q <= MS_STOP1;
                        scl_oe_o <= 1'b0;
                        cnt_q <= 12'h000;
                    end else begin
                        cnt_q <= cnt_q + 12'h001;
                    end
                end
                MS_STOP1: begin
                    if (!scl_s2_q) begin
                        cnt_q <= 12'h000;
                    end else if (last_cnt) begin
                        ms_q <= MS_STOP2;
                        sda_oe_o <= 1'b0;
                    end else begin
                        cnt_q <= cnt_q + 12'h001;
                    end
                end
                MS_STOP2: begin
                    sda_oe_o <= 1'b0;
                end
                default: ms_q <= MS_IDLE;
            endcase
            // slave holds the clock while its word waits for software
            if (!mst_q) begin
                scl_oe_o <= i2c & ~pin_q & aas_q;
            end
            // bit engine
            if (scl_rise) begin
                lrb_q <= sda_s2_q;
                bit_q <= bit_q + 4'h1;
                if (bit_q < nbits) begin
                    shift_q <= {shift_q[6:0], sda_s2_q};
                end
            end
            if (scl_fall && ms_q != MS_STOP0) begin
                if (done) begin
                    bit_q <= 4'h0;
                    first_q <= 1'b0;
                    sda_oe_o <= 1'b0;
                    if (active) begin
                        pin_q <= 1'b0;
                        if (!mst_q) begin
                            scl_oe_o <= 1'b1;
                        end
                    end
                    if (first_q && mst_q && !lrb_q) begin
                        trx_q <= ~addr_rw_q;
                    end
                    if (addressed) begin
                        aas_q <= 1'b1;
                        trx_q <= address_format_bit ? trx_q : shift_q[0];
                        ad0_q <= match & gcall;
                    end
                end else if (bit_q < nbits) begin
                    sda_oe_o <= active & trx_q & ~shift_q[7];
                end else begin
                    sda_oe_o <= ack_en & acking;
                end
            end
            if (arb_lost) begin
                al_q <= 1'b1;
                mst_q <= 1'b0;
                trx_q <= 1'b0;
                ms_q <= MS_IDLE;
                sda_oe_o <= 1'b0;
                scl_oe_o <= 1'b0;
            end
            if (start_det) begin
                bb_q <= 1'b1;
                cr1_q[`I2CBC_CR1_BC_HI:`I2CBC_CR1_BC_LO] <= 3'h0;
                first_q <= 1'b1;
                bit_q <= 4'h0;
                aas_q <= 1'b0;
                ad0_q <= 1'b0;
            end
            if (stop_det) begin
                bb_q <= 1'b0;
                mst_q <= 1'b0;
                trx_q <= 1'b0;
                aas_q <= 1'b0;
                ad0_q <= 1'b0;
                first_q <= 1'b0;
                bit_q <= 4'h0;
                ms_q <= MS_IDLE;
                sda_oe_o <= 1'b0;
                scl_oe_o <= 1'b0;
            end
            // pads stay released outside two-wire mode
            if (!i2c) begin
                scl_oe_o <= 1'b0;
                sda_oe_o <= 1'b0;
                ms_q <= MS_IDLE;
            end
        end
    end
endmodule // i2cbc_ctrl
`default_nettype wire

/* File: bench/i2cbc_ctrl_asserts.sv */
/* port-level checker for the two-wire bus controller.
   assumes apb on clk_sys_i and line levels fed back on scl_i. */
`timescale 1ns/1ps
`default_nettype none
module i2cbc_ctrl_asserts #(
    parameter [11:0] HALF_BASE = 12'h010
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic scl_i,
    input wire logic scl_oe_o,
    input wire logic sda_oe_o
);
    logic [1:0] mode_q;
    logic [15:0] low_q;
    logic [15:0] high_q;
    logic setup;
    logic unmapped;
    assign setup = psel_i && !penable_i;
    assign unmapped = paddr_i[11:2] < 10'h240 || paddr_i[11:2] > 10'h243;
    // soft reset is not tracked; it only lowers the mode, which is the safe side
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            mode_q <= 2'h0;
            low_q <= 16'h0000;
            high_q <= 16'h0000;
        end else begin
            if (psel_i && penable_i && pready_o && pwrite_i && paddr_i == 12'h90C) begin
                mode_q <= pwdata_i[3:2];
            end
            low_q <= scl_oe_o ? low_q + {15'h0000, low_q != 16'hFFFF} : 16'h0000;
            high_q <= scl_oe_o ? 16'h0000 : high_q + {15'h0000, high_q != 16'hFFFF};
        end
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    pready_timing_a: assert property (setup |=> pready_o)
        else $error("pready missing after setup");
    pready_cause_a: assert property (pready_o |-> $past(setup))
        else $error("pready without setup");
    unmapped_err_a: assert property (setup && unmapped |=> pslverr_o)
        else $error("no error for unmapped address");
    mapped_ok_a: assert property (setup && !unmapped |=> !pslverr_o)
        else $error("error for mapped address");
    err_read_zero_a: assert property (pslverr_o |-> prdata_o == 32'h00000000)
        else $error("refused access returned data");
    upper_zero_a: assert property (pready_o |-> prdata_o[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    port_release_a: assert property ((mode_q != 2'h2) [*4] |-> !scl_oe_o && !sda_oe_o)
        else $error("pads driven outside two-wire mode");
    scl_low_width_a: assert property ($fell(scl_oe_o) |-> low_q >= HALF_BASE - 12'h001)
        else $error("clock low phase too short");
    scl_high_width_a: assert property ($rose(scl_oe_o) && $past(scl_i) |-> high_q >= HALF_BASE)
        else $error("clock high phase too short");
endmodule // i2cbc_ctrl_asserts
bind i2cbc_ctrl i2cbc_ctrl_asserts #(.HALF_BASE(HALF_BASE)) i2cbc_ctrl_asserts_i (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .pwdata_i(pwdata_i),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .scl_i(scl_i),
    .scl_oe_o(scl_oe_o),
    .sda_oe_o(sda_oe_o)
);
`default_nettype wire

/* File: bench/i2cbc_slave_model.sv */
/* behavioural slave on the two-wire bus: takes the address word and acks it when it matches ADDR.
   assumes wired-and line levels; pull outputs high mean the line is pulled low. */
`timescale 1ns/1ps
`default_nettype none
module i2cbc_slave_model #(
    parameter logic [6:0] ADDR = 7'h3A
) (
    input wire logic clk_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic stretch_i,
    output logic sda_pull_o,
    output logic scl_pull_o,
    output logic [7:0] byte_o
);
    logic scl_q = 1'b1;
    logic sda_q = 1'b1;
    int bits = 9;
    int hold = 0;
    initial sda_pull_o = 1'b0;
    initial byte_o = 8'h00;
    assign scl_pull_o = hold != 0;
    always @(posedge clk_i) begin
        scl_q <= scl_i;
        sda_q <= sda_i;
        if (hold != 0) begin
            hold <= hold - 1;
        end
        if (scl_q && scl_i && sda_q != sda_i) begin
            bits <= sda_i ? 9 : 0;
        end else if (!scl_q && scl_i && bits < 8) begin
            byte_o <= {byte_o[6:0], sda_i};
            bits <= bits + 1;
        end else if (scl_q && !scl_i && bits == 8) begin
            sda_pull_o <= byte_o[7:1] == ADDR;
            hold <= stretch_i ? 40 : 0;
            bits <= 10;
        end else if (scl_q && !scl_i && bits == 10) begin
            sda_pull_o <= 1'b0;
            bits <= 9;
        end
    end
endmodule // i2cbc_slave_model
`default_nettype wire

/* File: bench/tb_i2c_bus_master_slave_ctrl.sv */
/* self-checking bench: apb master, wired-and lines and one slave model.
   assumes the design answers each apb access with one-cycle pready. */
`timescale 1ns/1ps
`default_nettype none
module tb_i2c_bus_master_slave_ctrl;
    localparam logic [6:0] SLV = 7'h3A;
    localparam logic [11:0] A_CR1 = 12'h900;
    localparam logic [11:0] A_DBR = 12'h904;
    localparam logic [11:0] A_OAR = 12'h908;
    localparam logic [11:0] A_CR2 = 12'h90C;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic stretch = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready, pslverr, scl_oe, sda_oe, sda_pull, scl_pull, scl_line, sda_line;
    logic [7:0] slv_byte;
    int err_total = 0;
    int samples_checked = 0;
    assign scl_line = ~(scl_oe | scl_pull);
    assign sda_line = ~(sda_oe | sda_pull);
    always #2 clk_sys = ~clk_sys;
    i2cbc_ctrl #(.HALF_BASE(12'h004)) i2cbc_ctrl_i (
        .clk_sys_i(clk_sys), .rst_i(rst), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .scl_i(scl_line), .scl_o(),
        .scl_oe_o(scl_oe), .sda_i(sda_line), .sda_o(), .sda_oe_o(sda_oe));
    i2cbc_slave_model #(.ADDR(SLV)) i2cbc_slave_model_i (
        .clk_i(clk_sys), .scl_i(scl_line), .sda_i(sda_line), .stretch_i(stretch),
        .sda_pull_o(sda_pull), .scl_pull_o(scl_pull), .byte_o(slv_byte));
    task automatic print_verdict;
        if (err_total == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] wd,
                       output logic [7:0] rd, output logic err);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, wd};
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        // look between edges so the answer is read while it stands
        @(negedge clk_sys);
        while (pready !== 1'b1 && n < 20) begin
            @(negedge clk_sys);
            n++;
        end
        rd = prdata[7:0];
        err = pslverr;
        @(posedge clk_sys);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
        if (n >= 20) begin
            err_total++;
            $display("mismatch pready expected 1 seen timeout");
            print_verdict;
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [7:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rdc(input logic [11:0] a, input string name, input logic [7:0] exp);
        logic [7:0] r;
        logic e;
        apb(1'b0, a, 8'h00, r, e);
        chk(name, exp, r);
    endtask
    // polls status only; a buffer access would set pending again
    task automatic wait_stat(input logic [7:0] mask, input logic [7:0] val);
        logic [7:0] s;
        logic e;
        for (int i = 0; i < 400; i++) begin
            apb(1'b0, A_CR2, 8'h00, s, e);
            if ((s & mask) === val) return;
        end
        err_total++;
        $display("mismatch status expected %h seen %h", val, s & mask);
        print_verdict;
    endtask
    task automatic s_regs;
        logic [7:0] r;
        logic e;
        rdc(A_CR1, "cr1_reset", 8'h00);
        wr(A_CR1, 8'hA5);
        rdc(A_CR1, "cr1_rw", 8'hA5);
        wr(A_CR2, 8'h18);
        rdc(A_CR2, "cr2_reads_status", 8'h10);
        apb(1'b0, 12'h910, 8'h00, r, e);
        chk("unmapped_err", 8'h01, {7'h00, e});
        chk("unmapped_data", 8'h00, r);
    endtask
    task automatic s_master(input logic rw, input logic slow);
        stretch <= slow;
        wr(A_CR1, 8'hB0);
        wr(A_DBR, {SLV, rw});
        wr(A_CR2, 8'hF8);
        wait_stat(8'h10, 8'h00);
        chk("slave_byte", {SLV, rw}, slv_byte);
        rdc(A_CR2, "status_addr", rw ? 8'hA0 : 8'hE0);
        rdc(A_CR1, "bitcount_cleared", 8'h10);
        chk("scl_held", 8'h01, {7'h00, scl_oe});
        wr(A_CR2, 8'hD8);
        wait_stat(8'h20, 8'h00);
        wait_stat(8'hC0, 8'h00);
    endtask
    task automatic s_modes;
        logic [1:0] m [3] = '{2'h0, 2'h1, 2'h3};
        wr(A_CR1, 8'h00);
        foreach (m[i]) begin
            wr(A_CR2, {4'h1, m[i], 2'h0});
            repeat (4) @(posedge clk_sys);
            @(negedge clk_sys);
            chk("pads_released", 8'h00, {6'h00, scl_oe, sda_oe});
        end
    endtask
    task automatic s_swrst;
        wr(A_CR1, 8'h55);
        wr(A_OAR, 8'h66);
        wr(A_CR2, 8'h0A);
        wr(A_CR2, 8'h09);
        repeat (2) @(posedge clk_sys);
        rdc(A_CR1, "cr1_after_swrst", 8'h00);
        rdc(A_OAR, "oar_after_swrst", 8'h00);
    endtask
    initial begin
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        s_regs;
        s_master(1'b0, 1'b0);
        s_master(1'b1, 1'b1);
        s_modes;
        s_swrst;
        print_verdict;
    end
endmodule // tb_i2c_bus_master_slave_ctrl
`default_nettype wire
